/* File: core/ers_pkg.sv */
// ers_pkg: constants for the external reset pin sequencer
// assumes a single 100 MHz core clock
package ers_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_DELAY_CYCLES = 2048; // internal delay, in clock cycles
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RST_DELAY_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_RST = 12'h000;
  // ---------------------------------------------------------------
  // operating modes of the controller
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_RUN = 2'h0;
  localparam logic [1:0] MODE_WAIT = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  // ---------------------------------------------------------------
  // sequencer states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_DELAY = 4'h2,
    ST_INIT = 4'h4,
    ST_RUN = 4'h8
  } ers_state_t;
endpackage : ers_pkg

/* File: core/ers_sync.sv */
// ers_sync: two-flop level synchroniser for the reset pin
// assumes pin is asynchronous; resets to the inactive (high) level
`timescale 1ns/1ps
module ers_sync (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic d_in,
  output logic q_out
);
  logic s1_r;
  logic s1_nxt;
  logic s2_r;
  logic s2_nxt;

  // next values; first stage only feeds the second
  always_comb begin
    s1_nxt = d_in;
    s2_nxt = s1_r;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  assign q_out = s2_r;
endmodule // ers_sync

/* File: core/ers_seq.sv */
// ers_seq: external reset pin sequencer (top)
// assumes pin driven by a board reset circuit; mode and init_done from core
// Functional notes
// - reset pin is active low, accepted in run, wait and stop
// - internal delay of 2048 clocks makes short pulses a valid reset
// - reset state held as long as the pin stays low
// - running program halted at once; nothing to halt in wait, yet CPU_HALT_OUT is raised there too
// - in run or wait: pins to input pull-up, oscillator restarted
// - in stop: oscillator started, pins to input pull-up
// - initialization begins only after the delay count expires
// - external reset outranks every other non-maskable event
// - initialization clears all port registers
`timescale 1ns/1ps
module ers_seq
  import ers_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic NRST_IN,
  input wire logic RST_PIN_N_IN,
  input wire logic [1:0] MODE_IN,
  input wire logic INIT_DONE_IN,
  output logic CORE_RST_OUT,
  output logic CPU_HALT_OUT,
  output logic PORT_FORCE_IPU_OUT,
  output logic OSC_RESTART_OUT,
  output logic OSC_START_OUT,
  output logic INIT_OUT,
  output logic PORT_CLEAR_OUT,
  output logic RST_EVENT_OUT
);
  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  logic pin_s;

  ers_sync u_sync (
    .clk_in(CLOCK_IN),
    .nrst_in(NRST_IN),
    .d_in(RST_PIN_N_IN),
    .q_out(pin_s)
  );

  logic pin_low;
  assign pin_low = ~pin_s;

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  ers_state_t state_r;
  ers_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic stop_r;
  logic stop_nxt;
  logic hold_pulse_r;
  logic hold_pulse_nxt;

  // state, delay count and remembered stop mode
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    stop_nxt = stop_r;
    hold_pulse_nxt = 1'b0;
    // pin low overrides any state, whatever the mode
    if (pin_low) begin
      if (state_r != ST_HOLD) begin
        stop_nxt = (MODE_IN == MODE_STOP);
        hold_pulse_nxt = 1'b1;
      end
      state_nxt = ST_HOLD;
      cnt_nxt = CNT_RST; // restart count on reassertion
    end else begin
      unique case (state_r)
        ST_HOLD: begin
          state_nxt = ST_DELAY;
          cnt_nxt = CNT_RST;
        end
        ST_DELAY: begin
          if (cnt_r == CNT_LAST) begin
            state_nxt = ST_INIT;
          end else begin
            cnt_nxt = cnt_r + 12'h001;
          end
        end
        ST_INIT: begin
          if (INIT_DONE_IN) begin
            state_nxt = ST_RUN;
            stop_nxt = 1'b0;
          end
        end
        ST_RUN: begin
          state_nxt = ST_RUN;
        end
      endcase
    end
  end

  // after system reset the device starts through the delay like a pin reset
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_r <= ST_DELAY;
      cnt_r <= CNT_RST;
      stop_r <= 1'b0;
      hold_pulse_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      stop_r <= stop_nxt;
      hold_pulse_r <= hold_pulse_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // registered outputs decoded from the next state
  logic core_rst_r;
  logic halt_r;
  logic ipu_r;
  logic osc_rst_r;
  logic osc_start_r;
  logic init_r;
  logic core_rst_nxt;
  logic halt_nxt;
  logic ipu_nxt;
  logic osc_rst_nxt;
  logic osc_start_nxt;
  logic init_nxt;

  always_comb begin
    core_rst_nxt = (state_nxt == ST_HOLD) || (state_nxt == ST_DELAY);
    halt_nxt = core_rst_nxt && (MODE_IN == MODE_RUN || state_nxt != ST_RUN);
    ipu_nxt = core_rst_nxt;
    osc_rst_nxt = (state_nxt == ST_HOLD) && !stop_nxt;
    osc_start_nxt = (state_nxt == ST_HOLD) && stop_nxt;
    init_nxt = (state_nxt == ST_INIT);
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      core_rst_r <= 1'b1;
      halt_r <= 1'b1;
      ipu_r <= 1'b1;
      osc_rst_r <= 1'b0;
      osc_start_r <= 1'b0;
      init_r <= 1'b0;
    end else begin
      core_rst_r <= core_rst_nxt;
      halt_r <= halt_nxt;
      ipu_r <= ipu_nxt;
      osc_rst_r <= osc_rst_nxt;
      osc_start_r <= osc_start_nxt;
      init_r <= init_nxt;
    end
  end

  assign CORE_RST_OUT = core_rst_r;
  assign CPU_HALT_OUT = halt_r;
  assign PORT_FORCE_IPU_OUT = ipu_r;
  assign OSC_RESTART_OUT = osc_rst_r;
  assign OSC_START_OUT = osc_start_r;
  assign INIT_OUT = init_r;
  assign PORT_CLEAR_OUT = init_r; // port registers cleared during init
  assign RST_EVENT_OUT = hold_pulse_r; // top priority event to the core

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // helper count of cycles spent in the delay, kept apart from cnt_r
  // so that a wrong end point in the sequencer cannot hide itself
  logic [CNT_W-1:0] dly_seen_r;
  logic [CNT_W-1:0] dly_seen_nxt;

  always_comb begin
    if (state_r == ST_DELAY) begin
      dly_seen_nxt = dly_seen_r + 12'h001;
    end else begin
      dly_seen_nxt = CNT_RST;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      dly_seen_r <= CNT_RST;
    end else begin
      dly_seen_r <= dly_seen_nxt;
    end
  end

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!NRST_IN);

  a_low_holds_reset: assert property (
    !pin_s |=> CORE_RST_OUT && !INIT_OUT) else $error("reset not held while pin low");
  a_pin_low_event: assert property (
    !pin_s && state_r == ST_RUN |=> RST_EVENT_OUT && CPU_HALT_OUT)
    else $error("pin low in run not taken");
  a_delay_length: assert property (
    state_r == ST_HOLD && pin_s |=> (CORE_RST_OUT && !INIT_OUT) [*8])
    else $error("init before delay");
  a_init_after_cnt: assert property (
    state_r == ST_DELAY && cnt_r == CNT_LAST && pin_s |=> INIT_OUT)
    else $error("init not entered at count end");
  a_restart_count: assert property (
    state_r == ST_DELAY && !pin_s |=> state_r == ST_HOLD && cnt_r == CNT_RST)
    else $error("count not restarted");
  a_stop_osc_start: assert property (
    !pin_s && state_r != ST_HOLD && MODE_IN == MODE_STOP |=> OSC_START_OUT && !OSC_RESTART_OUT)
    else $error("stop mode reset wrong oscillator action");
  a_run_osc_restart: assert property (
    !pin_s && state_r != ST_HOLD && MODE_IN != MODE_STOP |=> OSC_RESTART_OUT && PORT_FORCE_IPU_OUT)
    else $error("run or wait reset wrong action");
  a_init_clears: assert property (
    state_r == ST_INIT |-> PORT_CLEAR_OUT && !PORT_FORCE_IPU_OUT)
    else $error("ports not cleared in init");
  a_halt_in_reset: assert property (
    CORE_RST_OUT |-> CPU_HALT_OUT) else $error("program not halted");
  a_priority: assert property (
    $fell(pin_s) && state_r == ST_INIT |=> !INIT_OUT) else $error("reset lost to init");
  a_event_single: assert property (
    RST_EVENT_OUT |=> !RST_EVENT_OUT) else $error("reset event longer than one cycle");
  a_osc_drop: assert property (
    state_r == ST_HOLD && pin_s |=> !OSC_RESTART_OUT && !OSC_START_OUT && CORE_RST_OUT)
    else $error("oscillator request held into delay");
  a_delay_exact: assert property (
    $rose(INIT_OUT) |-> dly_seen_r == CNT_W'(RST_DELAY_CYCLES))
    else $error("delay length wrong");
  a_init_ends: assert property (
    state_r == ST_INIT && INIT_DONE_IN && pin_s |=> !INIT_OUT && !CORE_RST_OUT)
    else $error("init did not end on done");

  c_run_reset: cover property (state_r == ST_RUN ##1 state_r == ST_HOLD);
  c_stop_reset: cover property (OSC_START_OUT);
  c_count_restart: cover property (state_r == ST_DELAY ##1 state_r == ST_HOLD);
  c_init_done: cover property (state_r == ST_INIT ##1 state_r == ST_RUN);
  c_init_hit: cover property (state_r == ST_INIT && !pin_s);
endmodule // ers_seq

/* File: testbench/ers_board.sv */
// ers_board: board reset circuit, pulls the reset pin low on request
// assumes go_in is a one-cycle request with len_in of at least 1
`timescale 1ns/1ps
module ers_board (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [15:0] len_in,
  output logic rst_pin_n_out
);
  logic [15:0] cnt_r = 16'h0000;
  // ---------------------------------------------------------------
  // pulse timer
  // ---------------------------------------------------------------
  // counts the low time; the pin is driven back high once the count reaches zero
  always_ff @(posedge clk_in) begin
    if (go_in) begin
      cnt_r <= len_in;
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end
  assign rst_pin_n_out = (cnt_r == 16'h0000); // low means reset
endmodule // ers_board

/* File: testbench/ers_seq_tb.sv */
// ers_seq_tb: self-checking bench for the reset pin sequencer
// assumes the board model drives the pin; outputs sampled on falling edges
`timescale 1ns/1ps
module ers_seq_tb;
  import ers_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic [15:0] len = 16'h0001;
  logic [1:0] mode = MODE_RUN;
  logic done = 1'b0;
  logic pin_n;
  logic core_rst, halt, ipu, osc_re, osc_st, init, clr, evt;
  int n_fail = 0;
  int checked = 0;
  ers_board board (.clk_in(clk), .go_in(go), .len_in(len), .rst_pin_n_out(pin_n));
  ers_seq dut (.CLOCK_IN(clk), .NRST_IN(nrst), .RST_PIN_N_IN(pin_n), .MODE_IN(mode),
    .INIT_DONE_IN(done), .CORE_RST_OUT(core_rst), .CPU_HALT_OUT(halt),
    .PORT_FORCE_IPU_OUT(ipu), .OSC_RESTART_OUT(osc_re), .OSC_START_OUT(osc_st),
    .INIT_OUT(init), .PORT_CLEAR_OUT(clr), .RST_EVENT_OUT(evt));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end
  task automatic give_verdict();
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  // bounded wait on event, oscillator request or init; counts falling edges
  task automatic wcnt(input int w, input logic v, output int n);
    logic s;
    n = 0;
    s = (w == 0) ? evt : (w == 1) ? (osc_re | osc_st) : init;
    while (s !== v) begin
      @(negedge clk);
      n++;
      s = (w == 0) ? evt : (w == 1) ? (osc_re | osc_st) : init;
      if (n > 5000) begin
        chk(1'b0, 1'b1, "timeout");
        give_verdict();
      end
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic end_init();
    int n;
    wcnt(2, 1'b1, n);
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    @(negedge clk);
    chk({init, clr, core_rst}, 16'h0000, "init not ended");
  endtask
  // pulse of l cycles in mode m, full walk to the end of initialization
  task automatic pin_reset(input logic [1:0] m, input logic [15:0] l);
    int n;
    @(posedge clk);
    mode <= m;
    go <= 1'b1;
    len <= l;
    @(posedge clk);
    go <= 1'b0;
    wcnt(0, 1'b1, n);
    chk({core_rst, halt, ipu}, 16'h0007, "hold outputs");
    chk({osc_st, osc_re}, (m == MODE_STOP) ? 16'h0002 : 16'h0001, "osc req");
    @(negedge clk);
    chk(evt, 1'b0, "event width");
    wcnt(1, 1'b0, n);
    chk(16'(n), l - 16'h0001, "hold length");
    wcnt(2, 1'b1, n);
    chk(16'(n), 16'(RST_DELAY_CYCLES), "delay length");
    chk({clr, core_rst, halt, ipu}, 16'h0008, "init outputs");
    end_init();
  endtask
  // second pulse in mid-count restarts the delay from zero
  task automatic reassert();
    int n;
    @(posedge clk);
    go <= 1'b1;
    len <= 16'h0002;
    @(posedge clk);
    go <= 1'b0;
    wcnt(1, 1'b1, n);
    wcnt(1, 1'b0, n);
    repeat (1500) @(negedge clk);
    chk({init, core_rst}, 16'h0001, "mid count");
    pin_reset(MODE_WAIT, 16'h0003);
  endtask
  // pin pulse while initialization runs must win over it
  task automatic init_hit();
    int n;
    @(posedge clk);
    go <= 1'b1;
    len <= 16'h0001;
    @(posedge clk);
    go <= 1'b0;
    wcnt(2, 1'b1, n);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wcnt(0, 1'b1, n);
    chk(16'(n), 16'h0004, "event latency");
    chk({init, core_rst, evt}, 16'h0003, "reset over init");
    end_init();
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    chk({core_rst, init}, 16'h0002, "in reset");
    nrst <= 1'b1;
    end_init();
    pin_reset(MODE_RUN, 16'h0001);
    pin_reset(MODE_WAIT, 16'h0005);
    pin_reset(MODE_STOP, 16'h0001);
    pin_reset(2'h3, 16'h0004);
    pin_reset(MODE_RUN, 16'd300);
    reassert();
    init_hit();
    give_verdict();
  end
endmodule // ers_seq_tb
